//--- verilog/pad_pkg.sv
package pad_pkg;

    localparam int NUM_PINS = 8;
    localparam int NUM_CHAN = 5;
    localparam int CHSEL_W  = 3;
    localparam int ADR_W    = 8;
    localparam int DAT_W    = 32;

    // word offsets on the register bus
    localparam logic [7:0] OFS_LATCH  = 8'h00;
    localparam logic [7:0] OFS_DIR    = 8'h04;
    localparam logic [7:0] OFS_ADSEL  = 8'h08;
    localparam logic [7:0] OFS_CHSEL  = 8'h0c;
    localparam logic [7:0] OFS_AMPCTL = 8'h10;
    localparam logic [7:0] OFS_PROHIB = 8'h14;
    localparam logic [7:0] OFS_LEVEL  = 8'h18;

    // reset values: all pins input direction, analog selection
    localparam logic [7:0] RST_LATCH  = 8'h00;
    localparam logic [7:0] RST_DIR    = 8'hff;
    localparam logic [7:0] RST_ADSEL  = 8'h00;
    localparam logic [2:0] RST_CHSEL  = 3'h0;
    localparam logic [7:0] RST_AMPCTL = 8'h00;
    localparam logic [7:0] RST_ANA_SW = 8'hff;

    // amplifier control fields
    localparam int         AMP_ZERO_POS_INPUT_EN_BIT = 7;
    localparam int         AMP_ONE_POS_INPUT_EN_BIT = 3;
    localparam logic [7:0] AMPCTL_MASK = 8'h88;

    typedef enum logic [1:0] {
        KIND_PLAIN,
        KIND_AMP_IN,
        KIND_AMP_OUT_EXCL,
        KIND_AMP_OUT
    } pad_kind_e;

    typedef struct packed {
        logic dig;
        logic dir_in;
        logic amp_en;
        logic hit;
    } pad_pin_cfg_s;

    typedef struct packed {
        logic oe;
        logic ibuf;
        logic ana;
        logic conv;
        logic amp;
        logic prohib;
    } pad_pin_ctl_s;

    function automatic pad_kind_e pin_kind(input int idx);
        case (idx)
            0, 2, 5, 7: pin_kind = KIND_AMP_IN;
            1:          pin_kind = KIND_AMP_OUT_EXCL;
            6:          pin_kind = KIND_AMP_OUT;
            default:    pin_kind = KIND_PLAIN;
        endcase
    endfunction : pin_kind

endpackage : pad_pkg

//--- verilog/pad_pin_decode.sv
`timescale 1ns/1ps
`default_nettype none
module pad_pin_decode #(
    parameter pad_pkg::pad_kind_e KIND = pad_pkg::KIND_PLAIN
) (
    // pin configuration
    input  wire pad_pkg::pad_pin_cfg_s cfg_i,
    // decoded function
    output var  pad_pkg::pad_pin_ctl_s ctl_o
);

    pad_pkg::pad_pin_ctl_s next_ctl;

    always_comb begin
        next_ctl = '0;
        if (cfg_i.dig) begin
            // a selected channel would load the digital driver
            next_ctl.prohib = cfg_i.hit |
                ((KIND == pad_pkg::KIND_AMP_OUT_EXCL) & cfg_i.amp_en);
            if (!next_ctl.prohib) begin
                next_ctl.oe   = ~cfg_i.dir_in;
                next_ctl.ibuf = cfg_i.dir_in;
            end
        end else if (!cfg_i.dir_in) begin
            next_ctl.prohib = 1'b1;
        end else begin
            next_ctl.conv = cfg_i.hit;
            case (KIND)
                pad_pkg::KIND_AMP_IN: begin
                    next_ctl.amp = cfg_i.amp_en;
                    next_ctl.ana = ~cfg_i.amp_en | cfg_i.hit;
                end
                pad_pkg::KIND_AMP_OUT_EXCL,
                pad_pkg::KIND_AMP_OUT: begin
                    next_ctl.amp = cfg_i.amp_en;
                    next_ctl.ana = 1'b1;
                end
                default: begin
                    next_ctl.ana = 1'b1;
                end
            endcase
        end
    end

    assign ctl_o = next_ctl;

endmodule : pad_pin_decode
`default_nettype wire

//--- verilog/pad_in_gate.sv
`timescale 1ns/1ps
`default_nettype none
module pad_in_gate #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    // pin levels and buffer enables
    input  wire logic [WIDTH-1:0] pin_i,
    input  wire logic [WIDTH-1:0] ibuf_en_i,
    // gated level
    output logic      [WIDTH-1:0] level_o
);

    // a disabled buffer reads zero, so a floating analog pin never toggles
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            level_o <= '0;
        end else begin
            level_o <= pin_i & ibuf_en_i;
        end
    end

endmodule : pad_in_gate
`default_nettype wire

//--- verilog/pad_port.sv
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module pad_port #(
    parameter bit HAS_AMP = 1'b1
) (
    // clock and reset
    input  wire logic                         MCLK_I,
    input  wire logic                         RST_B_I,
    // wishbone slave
    input  wire logic                         WB_CYC_I,
    input  wire logic                         WB_STB_I,
    input  wire logic                         WB_WE_I,
    input  wire logic [pad_pkg::ADR_W-1:0]    WB_ADR_I,
    input  wire logic [3:0]                   WB_SEL_I,
    input  wire logic [pad_pkg::DAT_W-1:0]    WB_DAT_I,
    output logic      [pad_pkg::DAT_W-1:0]    WB_DAT_O,
    output logic                              WB_ACK_O,
    // pin side
    input  wire logic [pad_pkg::NUM_PINS-1:0] PIN_IN_I,
    output logic      [pad_pkg::NUM_PINS-1:0] PIN_OUT_O,
    output logic      [pad_pkg::NUM_PINS-1:0] PIN_OE_O,
    output logic      [pad_pkg::NUM_PINS-1:0] PIN_IBUF_EN_O,
    // converter mux and amplifiers
    output logic      [pad_pkg::NUM_PINS-1:0] ANALOG_SW_O,
    output logic      [pad_pkg::NUM_PINS-1:0] CONVERT_O,
    output logic      [pad_pkg::NUM_PINS-1:0] AMP_PIN_O,
    output logic      [pad_pkg::CHSEL_W-1:0]  CONV_CH_O,
    output logic                              AMP_ZERO_POS_INPUT_EN_O,
    output logic                              AMP_ONE_POS_INPUT_EN_O,
    output logic      [pad_pkg::NUM_PINS-1:0] PROHIB_O
);

    localparam int NP = pad_pkg::NUM_PINS;

    logic [NP-1:0]                 port_output_latch;
    logic [NP-1:0]                 pin_direction_reg;
    logic [NP-1:0]                 analog_digital_select_reg;
    logic [pad_pkg::CHSEL_W-1:0]   conversion_channel_select;
    logic [7:0]                    amplifier_control_reg;
    logic                          amp_zero_enable;
    logic                          amp_one_enable;
    logic [NP-1:0]                 hit;
    logic [NP-1:0]                 level;
    logic                          req;
    logic                          wr_en;
    pad_pkg::pad_pin_ctl_s [NP-1:0] ctl;
    logic [NP-1:0]                 ctl_oe;
    logic [NP-1:0]                 ctl_ibuf;
    logic [NP-1:0]                 ctl_ana;
    logic [NP-1:0]                 ctl_conv;
    logic [NP-1:0]                 ctl_amp;
    logic [NP-1:0]                 ctl_prohib;
    logic [pad_pkg::DAT_W-1:0]     next_rdata;

    // bus request: one wait state, ack drops the cycle after it rose
    assign req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wr_en = req & WB_WE_I & WB_SEL_I[0];

    assign amp_zero_enable =
        amplifier_control_reg[pad_pkg::AMP_ZERO_POS_INPUT_EN_BIT];
    assign amp_one_enable  =
        amplifier_control_reg[pad_pkg::AMP_ONE_POS_INPUT_EN_BIT];

    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= req;
        end
    end

    // output latch
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            port_output_latch <= pad_pkg::RST_LATCH;
        end else if (wr_en && WB_ADR_I == pad_pkg::OFS_LATCH) begin
            port_output_latch <= WB_DAT_I[NP-1:0];
        end
    end

    // direction, 1 = input
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            pin_direction_reg <= pad_pkg::RST_DIR;
        end else if (wr_en && WB_ADR_I == pad_pkg::OFS_DIR) begin
            pin_direction_reg <= WB_DAT_I[NP-1:0];
        end
    end

    // analog or digital selection, 1 = digital
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            analog_digital_select_reg <= pad_pkg::RST_ADSEL;
        end else if (wr_en && WB_ADR_I == pad_pkg::OFS_ADSEL) begin
            analog_digital_select_reg <= WB_DAT_I[NP-1:0];
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            conversion_channel_select <= pad_pkg::RST_CHSEL;
        end else if (wr_en && WB_ADR_I == pad_pkg::OFS_CHSEL) begin
            conversion_channel_select <= WB_DAT_I[pad_pkg::CHSEL_W-1:0];
        end
    end

    // builds without amplifiers keep these bits at zero
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            amplifier_control_reg <= pad_pkg::RST_AMPCTL;
        end else if (wr_en && WB_ADR_I == pad_pkg::OFS_AMPCTL) begin
            amplifier_control_reg <= HAS_AMP ?
                (WB_DAT_I[7:0] & pad_pkg::AMPCTL_MASK) : 8'h00;
        end
    end

    // per-pin function decode
    generate
        for (genvar i = 0; i < NP; i++) begin : g_pin
            localparam pad_pkg::pad_kind_e KIND = pad_pkg::pin_kind(i);
            pad_pkg::pad_pin_cfg_s cfg;

            // only the first channels reach pins; upper codes select none
            assign hit[i] = (i < pad_pkg::NUM_CHAN) &&
                (conversion_channel_select ==
                 pad_pkg::CHSEL_W'(i));
            assign cfg.dig    = analog_digital_select_reg[i];
            assign cfg.dir_in = pin_direction_reg[i];
            assign cfg.amp_en = (i < 4) ? amp_zero_enable
                                        : amp_one_enable;
            assign cfg.hit    = hit[i];

            pad_pin_decode #(
                .KIND (KIND)
            ) u_dec (
                .cfg_i (cfg),
                .ctl_o (ctl[i])
            );

            assign ctl_oe[i]     = ctl[i].oe;
            assign ctl_ibuf[i]   = ctl[i].ibuf;
            assign ctl_ana[i]    = ctl[i].ana;
            assign ctl_conv[i]   = ctl[i].conv;
            assign ctl_amp[i]    = ctl[i].amp;
            assign ctl_prohib[i] = ctl[i].prohib;
        end
    endgenerate

    // pin drivers, registered so the pads see no decode glitches
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            PIN_OUT_O     <= '0;
            PIN_OE_O      <= '0;
            PIN_IBUF_EN_O <= '0;
        end else begin
            PIN_OUT_O     <= port_output_latch & ctl_oe;
            PIN_OE_O      <= ctl_oe;
            PIN_IBUF_EN_O <= ctl_ibuf;
        end
    end

    // analog side
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            ANALOG_SW_O <= pad_pkg::RST_ANA_SW;
            CONVERT_O   <= '0;
            AMP_PIN_O   <= '0;
            PROHIB_O    <= '0;
            CONV_CH_O   <= pad_pkg::RST_CHSEL;
            AMP_ZERO_POS_INPUT_EN_O   <= 1'b0;
            AMP_ONE_POS_INPUT_EN_O   <= 1'b0;
        end else begin
            ANALOG_SW_O <= ctl_ana;
            CONVERT_O   <= ctl_conv;
            AMP_PIN_O   <= ctl_amp;
            PROHIB_O    <= ctl_prohib;
            CONV_CH_O   <= conversion_channel_select;
            AMP_ZERO_POS_INPUT_EN_O   <= amp_zero_enable;
            AMP_ONE_POS_INPUT_EN_O   <= amp_one_enable;
        end
    end

    pad_in_gate #(
        .WIDTH (NP)
    ) u_in_gate (
        .clk_i     (MCLK_I),
        .rst_b_i   (RST_B_I),
        .pin_i     (PIN_IN_I),
        .ibuf_en_i (PIN_IBUF_EN_O),
        .level_o   (level)
    );

    // read mux; unmapped words read zero and are still acknowledged
    always_comb begin
        next_rdata = '0;
        case (WB_ADR_I)
            pad_pkg::OFS_LATCH:  next_rdata[NP-1:0] = port_output_latch;
            pad_pkg::OFS_DIR:    next_rdata[NP-1:0] = pin_direction_reg;
            pad_pkg::OFS_ADSEL:
                next_rdata[NP-1:0] = analog_digital_select_reg;
            pad_pkg::OFS_CHSEL:
                next_rdata[pad_pkg::CHSEL_W-1:0] = conversion_channel_select;
            pad_pkg::OFS_AMPCTL: next_rdata[7:0] = amplifier_control_reg;
            pad_pkg::OFS_PROHIB: next_rdata[NP-1:0] = PROHIB_O;
            pad_pkg::OFS_LEVEL:  next_rdata[NP-1:0] = level;
            default:             next_rdata = '0;
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            WB_DAT_O <= '0;
        end else if (req && !WB_WE_I) begin
            WB_DAT_O <= next_rdata;
        end
    end

    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RST_B_I);

    a_dir_drives: assert property (
        PIN_OE_O == ($past(~pin_direction_reg) & PIN_OE_O))
        else $error("driver on while direction is input");

    a_latch_drive: assert property (
        (wr_en && WB_ADR_I == pad_pkg::OFS_LATCH &&
         analog_digital_select_reg[4] && !pin_direction_reg[4] &&
         !hit[4]) ##1 (analog_digital_select_reg[4] &&
         !pin_direction_reg[4] && !hit[4])
        |=> PIN_OE_O[4] && PIN_OUT_O[4] == $past(WB_DAT_I[4], 2))
        else $error("latch value not driven on pin 4");

    a_reset_analog: assert property (
        $rose(RST_B_I) |-> ANALOG_SW_O == pad_pkg::RST_ANA_SW &&
        PIN_OE_O == '0 && PIN_IBUF_EN_O == '0 ##1
        ANALOG_SW_O == pad_pkg::RST_ANA_SW)
        else $error("pins not analog inputs after reset");

    a_sel_blocks_dig: assert property (
        (analog_digital_select_reg[2] && hit[2]) |=>
        PROHIB_O[2] && !PIN_OE_O[2] && !PIN_IBUF_EN_O[2])
        else $error("selected digital pin 2 not blocked");

    a_amp_zero_pos_input_input: assert property (
        (!analog_digital_select_reg[0] && pin_direction_reg[0]) |=>
        AMP_PIN_O[0] == $past(amp_zero_enable) &&
        CONVERT_O[0] == $past(hit[0]) &&
        ANALOG_SW_O[0] == ($past(hit[0]) | !$past(amp_zero_enable)))
        else $error("pin 0 analog function wrong");

    a_amp_enable_bits: assert property (
        (HAS_AMP && wr_en && WB_ADR_I == pad_pkg::OFS_AMPCTL) |=> ##1
        AMP_ZERO_POS_INPUT_EN_O == $past(WB_DAT_I[7], 2) &&
        AMP_ONE_POS_INPUT_EN_O == $past(WB_DAT_I[3], 2))
        else $error("amplifier enable bit position wrong");

    a_pin1_excl: assert property (
        (analog_digital_select_reg[1] && (amp_zero_enable || hit[1])) |=>
        PROHIB_O[1] && !PIN_OE_O[1] && !PIN_IBUF_EN_O[1])
        else $error("pin 1 digital with amplifier or channel");

    a_pin1_amp_out: assert property (
        (!analog_digital_select_reg[1] && pin_direction_reg[1]) |=>
        ANALOG_SW_O[1] && AMP_PIN_O[1] == $past(amp_zero_enable) &&
        CONVERT_O[1] == $past(hit[1]))
        else $error("pin 1 analog function wrong");

    a_plain_pins: assert property (
        (analog_digital_select_reg[3] && !hit[3]) |=>
        PIN_OE_O[3] == !$past(pin_direction_reg[3]) &&
        PIN_IBUF_EN_O[3] == $past(pin_direction_reg[3]))
        else $error("pin 3 digital direction wrong");

    a_amp_one_pos_input_pins: assert property (
        (!analog_digital_select_reg[5] && pin_direction_reg[5] &&
         !analog_digital_select_reg[6] && pin_direction_reg[6]) |=>
        AMP_PIN_O[5] == $past(amp_one_enable) &&
        ANALOG_SW_O[5] == !$past(amp_one_enable) &&
        AMP_PIN_O[6] == $past(amp_one_enable) && ANALOG_SW_O[6])
        else $error("amplifier 1 pin function wrong");

    a_no_amp_build: assert property (
        !HAS_AMP |-> AMP_PIN_O == '0 && !AMP_ZERO_POS_INPUT_EN_O && !AMP_ONE_POS_INPUT_EN_O)
        else $error("amplifier function present in plain build");

    a_prohib_quiet: assert property (
        (!analog_digital_select_reg[7] && !pin_direction_reg[7]) |=>
        PROHIB_O[7] && !PIN_OE_O[7] && !PIN_IBUF_EN_O[7] && !AMP_PIN_O[7])
        else $error("prohibited pin 7 not quiet");

    a_pin0_digital: assert property (
        (analog_digital_select_reg[0] && !hit[0]) |=> !PROHIB_O[0] &&
        PIN_OE_O[0] == !$past(pin_direction_reg[0]) &&
        PIN_IBUF_EN_O[0] == $past(pin_direction_reg[0]))
        else $error("pin 0 digital direction wrong");

    a_pin4_analog: assert property (
        (!analog_digital_select_reg[4] && pin_direction_reg[4]) |=>
        ANALOG_SW_O[4] && !AMP_PIN_O[4] && CONVERT_O[4] == $past(hit[4]))
        else $error("pin 4 analog function wrong");

    a_pin6_digital: assert property (
        analog_digital_select_reg[6] |=> !PROHIB_O[6] &&
        PIN_OE_O[6] == !$past(pin_direction_reg[6]))
        else $error("pin 6 digital direction wrong");

    a_pin7_amp_in: assert property (
        (!analog_digital_select_reg[7] && pin_direction_reg[7]) |=>
        AMP_PIN_O[7] == $past(amp_one_enable) && !CONVERT_O[7] &&
        ANALOG_SW_O[7] == !$past(amp_one_enable))
        else $error("pin 7 amplifier input wrong");

    a_analog_quiet: assert property (
        PIN_OE_O == ($past(analog_digital_select_reg) & PIN_OE_O) &&
        PIN_IBUF_EN_O == ($past(analog_digital_select_reg) & PIN_IBUF_EN_O))
        else $error("digital buffer on an analog pin");

    c_dig_out: cover property (PIN_OE_O[4] && PIN_OUT_O[4]);
    c_amp_zero_pos_input_out: cover property (AMP_PIN_O[1] && CONVERT_O[1]);
    c_convert3: cover property (CONVERT_O[3] && ANALOG_SW_O[3]);
    c_prohib: cover property (PROHIB_O != '0);
    c_amp_one_pos_input_in: cover property (AMP_PIN_O[7] && AMP_ONE_POS_INPUT_EN_O);

endmodule : pad_port
`default_nettype wire

//--- verif/pad_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module pad_far_model (
    // pad side
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] out_i,
    input  wire logic [7:0] ext_i,
    output logic      [7:0] level_o,
    // converter mux side
    input  wire logic [7:0] ana_i,
    input  wire logic [7:0] conv_i,
    output logic            bad_o
);
    // driven pins read back the pad, the others carry the board level
    assign level_o = (oe_i & out_i) | (~oe_i & ext_i);
    // the mux converts one channel at most, and only through a closed switch
    assign bad_o = (|(conv_i & ~ana_i)) |
        !$onehot0(conv_i);
endmodule : pad_far_model
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [7:0] ad, dir;
        logic [2:0] ch;
        logic [7:0] amp, pr, cv;
    } pad_row_s;
    logic        clk, rst_b, cyc, stb, we, ack, a0, a1, bad;
    logic [3:0]  sel;
    logic [7:0]  adr, ext, lvl, pout, poe, pib, asw, conv, ampp, proh, ampn;
    logic [2:0]  cho;
    logic [31:0] wdat, dato, rd;
    int          num_errors = 0;
    int          n_checks = 0;
    // adsel, dir, chsel, ampctl, expected prohibited, expected converted
    pad_row_s rows[9] = '{
        '{8'hff, 8'hf0, 3'h5, 8'h00, 8'h00, 8'h00},
        '{8'h00, 8'hff, 3'h3, 8'h00, 8'h00, 8'h08},
        '{8'h00, 8'hff, 3'h0, 8'h88, 8'h00, 8'h01},
        '{8'h02, 8'hff, 3'h4, 8'h80, 8'h02, 8'h10},
        '{8'h1d, 8'hff, 3'h2, 8'h00, 8'h04, 8'h00},
        '{8'h00, 8'hfe, 3'h1, 8'h00, 8'h01, 8'h02},
        '{8'h02, 8'hff, 3'h1, 8'h00, 8'h02, 8'h00},
        '{8'he0, 8'h1f, 3'h4, 8'h08, 8'h00, 8'h10},
        '{8'h00, 8'hff, 3'h7, 8'h00, 8'h00, 8'h00}};

    pad_port i_pad_port (.MCLK_I(clk), .RST_B_I(rst_b), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(dato), .WB_ACK_O(ack), .PIN_IN_I(lvl),
        .PIN_OUT_O(pout), .PIN_OE_O(poe), .PIN_IBUF_EN_O(pib),
        .ANALOG_SW_O(asw), .CONVERT_O(conv), .AMP_PIN_O(ampp),
        .CONV_CH_O(cho), .AMP_ZERO_POS_INPUT_EN_O(a0), .AMP_ONE_POS_INPUT_EN_O(a1), .PROHIB_O(proh));
    // variant without amplifiers shares the bus; only its amp path is watched
    pad_port #(.HAS_AMP(1'b0)) i_pad_port_noamp (.MCLK_I(clk),
        .RST_B_I(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(),
        .WB_ACK_O(), .PIN_IN_I(lvl), .PIN_OUT_O(), .PIN_OE_O(),
        .PIN_IBUF_EN_O(), .ANALOG_SW_O(), .CONVERT_O(), .AMP_PIN_O(ampn),
        .CONV_CH_O(), .AMP_ZERO_POS_INPUT_EN_O(), .AMP_ONE_POS_INPUT_EN_O(), .PROHIB_O());
    pad_far_model i_pad_far_model (.oe_i(poe), .out_i(pout), .ext_i(ext),
        .level_o(lvl), .ana_i(asw), .conv_i(conv), .bad_o(bad));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task end_sim;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got,
                     exp);
        end
    endtask : chk

    // one classic cycle; entered just after a rising edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk(8'h00, 8'h01, "bus answer");
        r = dato;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk);
    endtask : wb

    // looked at mid-cycle: the first edge out of reset launches new values
    task check_reset;
        @(negedge clk);
        chk(asw, 8'hff, "reset analog switch");
        chk(poe | pib | ampp | proh, 8'h00, "reset outputs");
        chk({6'h0, a0, a1}, 8'h00, "reset amp enables");
        chk(conv, 8'h01, "reset channel 0 converted");
        @(posedge clk);
        wb(1'b0, pad_pkg::OFS_DIR, 32'h0, 4'h1, rd);
        chk(rd[7:0], pad_pkg::RST_DIR, "reset direction");
        wb(1'b0, pad_pkg::OFS_ADSEL, 32'h0, 4'h1, rd);
        chk(rd[7:0], pad_pkg::RST_ADSEL, "reset select");
    endtask : check_reset

    task check_row(input pad_row_s r);
        logic [7:0] e_oe, e_ib, e_ana, e_amp, m_ana, e_en;
        logic       ae, ap, dg, hit;
        for (int i = 0; i < 8; i++) begin
            dg = r.ad[i];
            hit = (i < pad_pkg::NUM_CHAN) && (r.ch == i);
            ae = (i < 4) ? r.amp[7] : r.amp[3];
            ap = (i != 3) && (i != 4);
            e_oe[i] = dg & ~r.dir[i] & ~r.pr[i];
            e_ib[i] = dg & r.dir[i] & ~r.pr[i];
            e_amp[i] = ~dg & r.dir[i] & ap & ae & ~r.pr[i];
            e_ana[i] = ~dg & ~r.pr[i] & ~(ap & ae & ~hit);
            // amp outputs left unselected: switch state is the designer's
            m_ana[i] = ~((i == 1 || i == 6) & ae & ~dg & ~r.pr[i] & ~hit);
        end
        e_en = {6'h0, r.amp[7], r.amp[3]};
        chk(poe, e_oe, "driver enable");
        chk(pout, 8'ha5 & e_oe, "output value");
        chk(pib, e_ib, "input buffer");
        chk(asw & m_ana, e_ana, "analog switch");
        chk(ampp, e_amp, "amp path");
        chk(conv, r.cv, "converted channel");
        chk(proh, r.pr, "prohibited flags");
        chk({5'h0, cho}, {5'h0, r.ch}, "channel copy");
        chk({6'h0, a0, a1}, e_en, "amp enables");
        chk(ampn, 8'h00, "amplifiers removed");
        chk({7'h0, bad}, 8'h00, "converter mux");
        wb(1'b0, pad_pkg::OFS_PROHIB, 32'h0, 4'h1, rd);
        chk(rd[7:0], r.pr, "prohibited readback");
    endtask : check_row

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_sim();
    end

    initial begin
        rst_b = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; sel = 4'h0;
        adr = 8'h00; wdat = 32'h0; ext = 8'h00;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check_reset();
        wb(1'b1, pad_pkg::OFS_LATCH, 32'ha5, 4'h1, rd);
        foreach (rows[k]) begin
            wb(1'b1, pad_pkg::OFS_ADSEL, {24'h0, rows[k].ad}, 4'h1, rd);
            wb(1'b1, pad_pkg::OFS_DIR, {24'h0, rows[k].dir}, 4'h1, rd);
            wb(1'b1, pad_pkg::OFS_CHSEL, {29'h0, rows[k].ch}, 4'h1, rd);
            wb(1'b1, pad_pkg::OFS_AMPCTL, {24'h0, rows[k].amp}, 4'h1, rd);
            repeat (2) @(posedge clk);
            check_row(rows[k]);
        end
        // lane 0 off: the write is acked but must not land
        wb(1'b1, pad_pkg::OFS_DIR, 32'h0, 4'he, rd);
        wb(1'b0, pad_pkg::OFS_DIR, 32'h0, 4'h1, rd);
        chk(rd[7:0], 8'hff, "masked write");
        wb(1'b1, 8'h1c, 32'hff, 4'h1, rd);
        wb(1'b0, 8'h1c, 32'h0, 4'h1, rd);
        chk(rd[7:0], 8'h00, "unmapped read");
        wb(1'b1, pad_pkg::OFS_AMPCTL, 32'hff, 4'h1, rd);
        wb(1'b0, pad_pkg::OFS_AMPCTL, 32'h0, 4'h1, rd);
        chk(rd[7:0], pad_pkg::AMPCTL_MASK, "amp ctl bits");
        wb(1'b1, pad_pkg::OFS_AMPCTL, 32'h0, 4'h1, rd);
        // digital pins 3 and 4 only, both left as inputs
        wb(1'b1, pad_pkg::OFS_ADSEL, 32'h18, 4'h1, rd);
        wb(1'b1, pad_pkg::OFS_CHSEL, 32'h0, 4'h1, rd);
        ext <= 8'h5a;
        repeat (3) @(posedge clk);
        wb(1'b0, pad_pkg::OFS_LEVEL, 32'h0, 4'h1, rd);
        chk(rd[7:0], 8'h18, "input level");
        ext <= 8'ha5;
        repeat (3) @(posedge clk);
        wb(1'b0, pad_pkg::OFS_LEVEL, 32'h0, 4'h1, rd);
        chk(rd[7:0], 8'h00, "input level");
        // pin 4 as digital output shows the latch
        wb(1'b1, pad_pkg::OFS_DIR, 32'hef, 4'h1, rd);
        wb(1'b1, pad_pkg::OFS_LATCH, 32'h5a, 4'h1, rd);
        chk(poe, 8'h10, "pin 4 driver");
        chk(pout, 8'h10, "pin 4 latch value");
        wb(1'b0, pad_pkg::OFS_LATCH, 32'h0, 4'h1, rd);
        chk(rd[7:0], 8'h5a, "latch readback");
        // reset again in mid-run with amplifiers on
        wb(1'b1, pad_pkg::OFS_AMPCTL, 32'h88, 4'h1, rd);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check_reset();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
